// file: uic_pkg.sv
// Package: register map, field layout and carriers for the interrupt clear and ident bank
// Behaviour
// - Writing one to bit 8 of interrupt_clear clears the pending parity error interrupt; bit reads zero after reset.
// - Writing one to bit 6 of interrupt_clear clears the pending receive time-out interrupt; bit reads zero.
// - Writing one to bit 5 of interrupt_clear clears the pending transmit interrupt; bit reads zero.
// - Writing one to bit 4 of interrupt_clear clears the pending receive interrupt; bit reads zero.
// - A zero written to any clear bit leaves that interrupt untouched, so only sources written with one are cleared.
// - Bits 3 to 0 of interrupt_clear are reserved and read zero; software keeps them on read-modify-write.
// - The ident registers are fixed read-only constants, writes do nothing and bits 31 to 8 read zero.
// - The ident register at 0xfd0 returns bits 7 to 0 of the peripheral ident word in its low byte.
// - The ident register at 0xfd4 returns bits 15 to 8 of the peripheral ident word in its low byte.
`default_nettype none

package uic_pkg;

   // Byte addresses of the registers
   localparam logic [11:0] ICR_OFFSET        = 12'h044;
   localparam logic [11:0] IDENT_LOW_OFFSET  = 12'hfd0;
   localparam logic [11:0] IDENT_SEC_OFFSET  = 12'hfd4;
   localparam logic [11:0] STATUS_OFFSET     = 12'h03c;

   // Field layout of the clear register and the ident word
   localparam int RX_IRQ_BIT        = 4;
   localparam int TX_IRQ_BIT        = 5;
   localparam int RX_TIMEOUT_BIT    = 6;
   localparam int FRAMING_ERR_BIT   = 7;
   localparam int PARITY_ERR_BIT    = 8;
   localparam int SRC_LSB           = 4;
   localparam int SRC_COUNT         = 5;
   localparam int IDENT_LOW_LSB     = 0;
   localparam int IDENT_SEC_LSB     = 8;

   // Reset and default read values
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
   localparam logic [SRC_COUNT-1:0] SRC_RESET = 5'h00;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // Avalon-MM slave request
   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } uic_req_type;

   // Avalon-MM slave answer
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } uic_rsp_type;

endpackage : uic_pkg

`default_nettype wire

// file: uic_ident_rom.sv
// Fixed identification bytes, read-only
`default_nettype none

module uic_ident_rom #(
   parameter logic [31:0] IDENT_WORD = 32'h0000_0000  // Arbitrary neutral value
) (
   input  wire logic [11:0] addr_in,
   output logic             hit_out,
   output logic [31:0]      data_out
);

   // Constant decode; no storage so writes cannot alter it
   always_comb
   begin
      hit_out  = 1'b0;
      data_out = uic_pkg::ZERO_WORD;
      if (addr_in == uic_pkg::IDENT_LOW_OFFSET)
      begin
         hit_out       = 1'b1;
         data_out[7:0] = IDENT_WORD[uic_pkg::IDENT_LOW_LSB +: 8];
      end
      else if (addr_in == uic_pkg::IDENT_SEC_OFFSET)
      begin
         hit_out       = 1'b1;
         data_out[7:0] = IDENT_WORD[uic_pkg::IDENT_SEC_LSB +: 8];
      end
   end

endmodule : uic_ident_rom

`default_nettype wire

// file: uic_src_flags.sv
// Pending interrupt flags: set by the port, cleared by write-one strobes
`default_nettype none

module uic_src_flags #(
   parameter int N = 5
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [N-1:0] set_in,
   input  wire logic [N-1:0] clear_in,
   output logic [N-1:0]      pending_out
);

   typedef struct packed {
      logic [N-1:0] pend;
   } uic_flag_state_type;

   uic_flag_state_type state_reg;
   uic_flag_state_type state_next;

   // Per source: set beats clear so no event is lost
   always_comb
   begin
      state_next = state_reg;
      for (int i = 0; i < N; i++)
      begin
         if (set_in[i])
            state_next.pend[i] = 1'b1;
         else if (clear_in[i])
            state_next.pend[i] = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign pending_out = state_reg.pend;

endmodule : uic_src_flags

`default_nettype wire

// file: uic_clear_bank.sv
// Top: Avalon-MM register bank with write-one-to-clear interrupt clears and ident registers
//
// Our own choice: the Avalon-MM interface to the registers.
`default_nettype none

module uic_clear_bank #(
   parameter logic [31:0] IDENT_WORD = 32'h0000_0000  // Arbitrary neutral value
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [11:0] avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic [4:0]  irq_raw_set_in,
   output logic [4:0]       irq_clear_out,
   output logic [4:0]       irq_pending_out
);

   localparam int N = uic_pkg::SRC_COUNT;

   // Bus-side bank state in one struct; the pending flags live in u_flags
   typedef struct packed {
      logic         ack;       // Answer cycle of the current access
      logic [31:0]  rdata;
      logic [N-1:0] clr;       // One-cycle clear strobes
   } uic_state_type;

   uic_state_type      state_reg;
   uic_state_type      state_next;
   uic_pkg::uic_req_type req;
   logic               ident_hit;
   logic [31:0]        ident_data;
   logic [N-1:0]       pending;
   logic               access;

   // Bundle the bus inputs
   always_comb
   begin
      req.address    = avs_address_in;
      req.read       = avs_read_in;
      req.write      = avs_write_in;
      req.writedata  = avs_writedata_in;
      req.byteenable = avs_byteenable_in;
   end

   uic_ident_rom #(
      .IDENT_WORD (IDENT_WORD)
   ) u_ident (
      .addr_in  (req.address),
      .hit_out  (ident_hit),
      .data_out (ident_data)
   );

   uic_src_flags #(
      .N (N)
   ) u_flags (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .set_in      (irq_raw_set_in),
      .clear_in    (state_reg.clr),
      .pending_out (pending)
   );

   assign access = req.read | req.write;

   // One wait cycle then ack; strobes fire once per accepted clear register write with byte lanes 1:0 enabled
   always_comb
   begin
      state_next     = state_reg;
      state_next.clr = '0;
      state_next.ack = access & ~state_reg.ack;
      if (access && !state_reg.ack)
      begin
         state_next.rdata = uic_pkg::UNMAPPED_READ;
         if (req.read)
         begin
            if (ident_hit)
               state_next.rdata = ident_data;
            else if (req.address == uic_pkg::STATUS_OFFSET)
               state_next.rdata[uic_pkg::SRC_LSB +: N] = pending;
            // Clear register reads zero: W1C bits and reserved low nibble
            else if (req.address == uic_pkg::ICR_OFFSET)
               state_next.rdata = uic_pkg::ZERO_WORD;
         end
         else if (req.address == uic_pkg::ICR_OFFSET && req.byteenable[1] && req.byteenable[0])
         begin
            // Only ones clear; zeros pass through as no effect, bits 3:0 ignored
            state_next.clr[uic_pkg::RX_IRQ_BIT - uic_pkg::SRC_LSB]      =
               req.writedata[uic_pkg::RX_IRQ_BIT];
            state_next.clr[uic_pkg::TX_IRQ_BIT - uic_pkg::SRC_LSB]      =
               req.writedata[uic_pkg::TX_IRQ_BIT];
            state_next.clr[uic_pkg::RX_TIMEOUT_BIT - uic_pkg::SRC_LSB]  =
               req.writedata[uic_pkg::RX_TIMEOUT_BIT];
            state_next.clr[uic_pkg::FRAMING_ERR_BIT - uic_pkg::SRC_LSB] =
               req.writedata[uic_pkg::FRAMING_ERR_BIT];
            state_next.clr[uic_pkg::PARITY_ERR_BIT - uic_pkg::SRC_LSB]  =
               req.writedata[uic_pkg::PARITY_ERR_BIT];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   // Outputs
   assign avs_waitrequest_out = access & ~state_reg.ack;
   assign avs_readdata_out    = state_reg.rdata;
   assign irq_clear_out       = state_reg.clr;
   assign irq_pending_out     = pending;

   // Checks
   a_clear_parity: assert property (@(posedge clk_in) disable iff (rst_in)
      (avs_write_in && !avs_waitrequest_out && avs_address_in == uic_pkg::ICR_OFFSET && avs_byteenable_in[1:0] == 2'h3
       && avs_writedata_in[8]) |-> irq_clear_out[4]) else $error("parity clear missing");
   a_clear_framing: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(state_reg.ack) && $past(avs_write_in) && $past(avs_address_in) == uic_pkg::ICR_OFFSET
       && $past(avs_byteenable_in[1:0]) == 2'h3 |-> irq_clear_out[3] == $past(avs_writedata_in[7]))
      else $error("framing clear wrong");
   a_clear_timeout: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_clear_out[2] && !irq_raw_set_in[2] |=> !irq_pending_out[2]) else $error("timeout not cleared");
   a_clear_tx: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_clear_out[1] |-> $past(avs_writedata_in[5]) && $past(avs_write_in)) else $error("tx clear spurious");
   a_clear_rx: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_clear_out[0] |-> $past(avs_writedata_in[4])) else $error("rx clear spurious");
   a_zero_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_pending_out[0] && !irq_clear_out[0] |=> irq_pending_out[0]) else $error("pending lost");
   a_icr_reads_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      avs_read_in && avs_address_in == uic_pkg::ICR_OFFSET && !avs_waitrequest_out |-> avs_readdata_out == 32'h0)
      else $error("clear register read nonzero");
   a_ident_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == uic_pkg::IDENT_SEC_OFFSET
      |-> avs_readdata_out == {24'h0, IDENT_WORD[15:8]}) else $error("ident second byte wrong");
   a_ident_low: assert property (@(posedge clk_in) disable iff (rst_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == uic_pkg::IDENT_LOW_OFFSET
      |-> avs_readdata_out == {24'h0, IDENT_WORD[7:0]}) else $error("ident low byte wrong");
   a_wait_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait too long");

   c_icr_write: cover property (@(posedge clk_in) disable iff (rst_in) |irq_clear_out);
   c_ident_read: cover property (@(posedge clk_in) disable iff (rst_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == uic_pkg::IDENT_LOW_OFFSET);
   c_set_clear: cover property (@(posedge clk_in) disable iff (rst_in) irq_raw_set_in[0] && irq_clear_out[0]);

endmodule : uic_clear_bank

`default_nettype wire

// file: uic_clear_bank_test.sv
// Self-checking bench for the interrupt clear and ident register bank
`default_nettype none

module uic_clear_bank_test;
   timeunit 1ns;
   timeprecision 1ps;

   // Arbitrary neutral ident word, its two low bytes different so lane slips show
   localparam logic [31:0] IDENT = 32'h0000_5ac3;

   logic        clk_in;
   logic        rst_in;
   logic [11:0] avs_address_in;
   logic        avs_read_in;
   logic        avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [3:0]  avs_byteenable_in;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out;
   logic [4:0]  irq_raw_set_in;
   logic [4:0]  irq_clear_out;
   logic [4:0]  irq_pending_out;
   int          n_errors;
   int          comparisons;
   logic [31:0] rd;
   logic [4:0]  clr_seen;
   logic [4:0]  exp_pend;

   uic_clear_bank #(
      .IDENT_WORD (IDENT)
   ) i_uic_clear_bank (
      .clk_in              (clk_in),
      .rst_in              (rst_in),
      .avs_address_in      (avs_address_in),
      .avs_read_in         (avs_read_in),
      .avs_write_in        (avs_write_in),
      .avs_writedata_in    (avs_writedata_in),
      .avs_byteenable_in   (avs_byteenable_in),
      .avs_readdata_out    (avs_readdata_out),
      .avs_waitrequest_out (avs_waitrequest_out),
      .irq_raw_set_in      (irq_raw_set_in),
      .irq_clear_out       (irq_clear_out),
      .irq_pending_out     (irq_pending_out)
   );

   // 40 MHz bus clock
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One Avalon cycle; request held until the rising edge that sees waitrequest low,
   // answer taken at that edge before the design's registers move on
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      int   n;
      logic done;
      @(posedge clk_in);
      avs_address_in    <= a;
      avs_read_in       <= ~wr;
      avs_write_in      <= wr;
      avs_writedata_in  <= d;
      avs_byteenable_in <= be;
      n    = 0;
      done = 1'b0;
      while (!done && n < 20)
      begin
         @(posedge clk_in);
         n++;
         if (avs_waitrequest_out === 1'b0)
         begin
            done     = 1'b1;
            rd       = avs_readdata_out;
            clr_seen = irq_clear_out;
            avs_read_in  <= 1'b0;
            avs_write_in <= 1'b0;
         end
      end
      if (!done)
      begin
         n_errors++;
         test_done();
      end
   endtask : bus

   // Flags are registered, so give the clear two edges to land
   task automatic settle_pend();
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check({27'h0, irq_pending_out}, {27'h0, exp_pend});
   endtask : settle_pend

   task automatic pulse(input logic [4:0] v);
      @(posedge clk_in);
      irq_raw_set_in <= v;
      @(posedge clk_in);
      irq_raw_set_in <= 5'h00;
   endtask : pulse

   // Main sequence
   initial
   begin
      rst_in = 1'b1;
      avs_address_in = 12'h000;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0000_0000;
      avs_byteenable_in = 4'h0;
      irq_raw_set_in = 5'h00;
      n_errors = 0;
      comparisons = 0;
      exp_pend = 5'h00;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      settle_pend();
      bus(1'b0, uic_pkg::ICR_OFFSET, 32'h0, 4'hf);
      check(rd, 32'h0000_0000);
      bus(1'b0, uic_pkg::IDENT_LOW_OFFSET, 32'h0, 4'hf);
      check(rd, {24'h0, IDENT[7:0]});
      bus(1'b0, uic_pkg::IDENT_SEC_OFFSET, 32'h0, 4'hf);
      check(rd, {24'h0, IDENT[15:8]});
      // Writes to the ident words must not stick
      bus(1'b1, uic_pkg::IDENT_LOW_OFFSET, 32'hffff_ffff, 4'hf);
      bus(1'b0, uic_pkg::IDENT_LOW_OFFSET, 32'h0, 4'hf);
      check(rd, {24'h0, IDENT[7:0]});
      bus(1'b1, uic_pkg::IDENT_SEC_OFFSET, 32'hffff_ffff, 4'hf);
      bus(1'b0, uic_pkg::IDENT_SEC_OFFSET, 32'h0, 4'hf);
      check(rd, {24'h0, IDENT[15:8]});
      bus(1'b0, 12'h100, 32'h0, 4'hf);
      check(rd, uic_pkg::UNMAPPED_READ);
      $display("test ident registers done");

      pulse(5'h1f);
      exp_pend = 5'h1f;
      settle_pend();
      // Zeros in the source field, ones in the reserved field and a write without byte lanes 1:0 clear nothing
      bus(1'b1, uic_pkg::ICR_OFFSET, 32'h0000_000f, 4'hf);
      check({27'h0, clr_seen}, 32'h0);
      settle_pend();
      bus(1'b1, uic_pkg::ICR_OFFSET, 32'h0000_0110, 4'hc);
      check({27'h0, clr_seen}, 32'h0);
      bus(1'b0, uic_pkg::ICR_OFFSET, 32'h0, 4'hf);
      check(rd, 32'h0000_0000);
      // One source at a time, the others must stay pending
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b1, uic_pkg::ICR_OFFSET, 32'h1 << (4 + i), 4'hf);
         check({27'h0, clr_seen}, 32'h1 << i);
         exp_pend[i] = 1'b0;
         settle_pend();
         bus(1'b0, uic_pkg::STATUS_OFFSET, 32'h0, 4'hf);
         check(rd, {23'h0, exp_pend, 4'h0});
      end
      // Two sources cleared by one write
      pulse(5'h1f);
      bus(1'b1, uic_pkg::ICR_OFFSET, 32'h0000_0110, 4'hf);
      check({27'h0, clr_seen}, 32'h0000_0011);
      exp_pend = 5'h0e;
      settle_pend();
      $display("test interrupt clears done");
      test_done();
   end

endmodule : uic_clear_bank_test

`default_nettype wire
